// ### pkg/oxad_pkg.sv
// types shared by the xbus address decoder and its bench
// assumes nothing beyond a systemverilog compiler
package oxad_pkg;

  // where a decoded access goes
  typedef enum logic [3:0] {
    TGT_EXT,
    TGT_FLASH_TEST,
    TGT_FLASH,
    TGT_SMALL_EXTENSION_RAM,
    TGT_LARGE_EXTENSION_RAM,
    TGT_FIRST_CAN_CONTROLLER,
    TGT_SECOND_CAN_CONTROLLER,
    TGT_RTC,
    TGT_PWM,
    TGT_ASC,
    TGT_SSC,
    TGT_I2C,
    TGT_MISC
  } oxad_target_t;

  typedef enum logic {
    ST_IDLE,
    ST_WAIT
  } oxad_state_t;

endpackage

// ### pkg/oxad_regs.svh
// address map, enable bit positions, reset values and wait counts of the xbus address decoder
// assumes a 24-bit byte address from the cpu and 16-bit configuration words held outside
//
// Summary of operation
// - small ram mapped only when both enables set
// - small ram disabled: range goes external
// - large ram at programmed window when enabled
// - global enable clear: large window goes external
// - large ram window starts 09'0000h after reset
// - 8k variant mirrors every 8k boundary
// - 16k variant decodes 09'0000h to 09'3FFFh
// - ram accesses: no waits, byte and word
// - first can window needs global and bit0
// - second can window needs global and bit1
// - rtc window needs global and bit4
// - extra pwm window needs global and bit6
// - second async serial needs global and bit7
// - second sync serial needs global and bit8
// - i2c window needs global and bit9
// - misc features window needs global and bit10
// - peripheral windows: word only, two waits
// - can in use: four segment address lines
// - disabled peripheral claims nothing, stays invisible
// - bootstrap shows flash test sector at zero
// - one 16-mbyte space, byte and word
`ifndef OXAD_REGS_SVH
`define OXAD_REGS_SVH

// ---------------------------------------------------------------
// enable bit positions in the peripheral config word
// ---------------------------------------------------------------
`define OXAD_EN_FIRST_CAN_CONTROLLER 0
`define OXAD_EN_SECOND_CAN_CONTROLLER 1
`define OXAD_EN_SMALL_EXTENSION_RAM 2
`define OXAD_EN_LARGE_EXTENSION_RAM 3
`define OXAD_EN_RTC 4
`define OXAD_EN_PWM 6
`define OXAD_EN_ASC 7
`define OXAD_EN_SSC 8
`define OXAD_EN_I2C 9
`define OXAD_EN_MISC 10

// ---------------------------------------------------------------
// fixed windows: peripheral pages as address bits [23:8], ram and flash bounds as full addresses
// ---------------------------------------------------------------
`define OXAD_PG_FIRST_CAN_CONTROLLER 16'h00EF
`define OXAD_PG_SECOND_CAN_CONTROLLER 16'h00EE
`define OXAD_PG_RTC 16'h00ED
`define OXAD_PG_PWM 16'h00EC
`define OXAD_PG_ASC 16'h00E9
`define OXAD_PG_SSC 16'h00E8
`define OXAD_PG_I2C 16'h00EA
`define OXAD_PG_MISC 16'h00EB
`define OXAD_SMALL_EXTENSION_RAM_LO 24'h00E000
`define OXAD_SMALL_EXTENSION_RAM_HI 24'h00E7FF
`define OXAD_TEST_HI 24'h001FFF
`define OXAD_FL_A_HI 24'h007FFF
`define OXAD_FL_B_LO 24'h018000
`define OXAD_FL_B_HI 24'h04FFFF

// ---------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------
// window word: [15:4] start bits 23:12, [3:0] size code, 4 kbyte << code
`define OXAD_LARGE_EXTENSION_RAM_WIN_RST 16'h0902
`define OXAD_XBUS_WAITS 2'h2
`define OXAD_RAM_WAITS 2'h0
`define OXAD_SEG_LINES_FULL 4'h8
`define OXAD_SEG_LINES_CAN 4'h4

`endif

// ### rtl/oxad_decoder.sv
// cpu address decoder for on-chip ram, xbus peripherals and the external bus
// assumes one request at a time from the cpu, held configuration levels and
// a single 10 mhz clock with synchronous active-high reset
`include "oxad_regs.svh"

module oxad_decoder #(
  parameter int LARGE_XRAM_KB = 16,
  parameter int EXT_WAITS = 1,
  parameter int N_SEL = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [23:0] i_addr,
  input wire logic i_byte,
  input wire logic i_bootstrap,
  input wire logic i_xbus_global_enable,
  input wire logic [15:0] i_xbus_periph_config,
  input wire logic i_xram_win_load,
  input wire logic [15:0] i_xram_win_data,
  input wire logic [15:0] i_ext_address_select [N_SEL],
  output logic o_busy,
  output logic o_sel_valid,
  output oxad_pkg::oxad_target_t o_target,
  output logic [13:0] o_ram_index,
  output logic [2:0] o_ext_set,
  output logic o_access_error,
  output logic o_done,
  output logic [15:0] o_large_xram_window_select,
  output logic [7:0] o_periph_visible,
  output logic [3:0] o_seg_addr_lines
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (LARGE_XRAM_KB != 8 && LARGE_XRAM_KB != 16) begin : g_bad_ram
    $error("LARGE_XRAM_KB must be 8 or 16");
  end
  if (EXT_WAITS < 0 || EXT_WAITS > 3) begin : g_bad_wait
    $error("EXT_WAITS must be 0 to 3");
  end
  if (N_SEL < 1 || N_SEL > 7) begin : g_bad_sel
    $error("N_SEL must be 1 to 7");
  end

  // ---------------------------------------------------------------
  // peripheral window table
  // ---------------------------------------------------------------
  localparam logic [15:0] PAGE [8] = '{`OXAD_PG_FIRST_CAN_CONTROLLER, `OXAD_PG_SECOND_CAN_CONTROLLER, `OXAD_PG_RTC, `OXAD_PG_PWM,
                                      `OXAD_PG_ASC, `OXAD_PG_SSC, `OXAD_PG_I2C, `OXAD_PG_MISC};
  localparam int ENBIT [8] = '{`OXAD_EN_FIRST_CAN_CONTROLLER, `OXAD_EN_SECOND_CAN_CONTROLLER, `OXAD_EN_RTC, `OXAD_EN_PWM,
                               `OXAD_EN_ASC, `OXAD_EN_SSC, `OXAD_EN_I2C, `OXAD_EN_MISC};
  localparam oxad_pkg::oxad_target_t PTGT [8] = '{oxad_pkg::TGT_FIRST_CAN_CONTROLLER, oxad_pkg::TGT_SECOND_CAN_CONTROLLER,
      oxad_pkg::TGT_RTC, oxad_pkg::TGT_PWM, oxad_pkg::TGT_ASC, oxad_pkg::TGT_SSC,
      oxad_pkg::TGT_I2C, oxad_pkg::TGT_MISC};
  localparam logic [1:0] EXT_W = 2'(EXT_WAITS);
  localparam logic [13:0] RAM_MASK = (LARGE_XRAM_KB == 8) ? 14'h1FFF : 14'h3FFF;

  // window word match: start in [15:4], size 4 kbyte << code in [3:0]
  function automatic logic win_hit(input logic [23:0] a, input logic [15:0] w);
    logic [11:0] low;
    low = (12'h001 << w[3:0]) - 12'h001;
    return ((a[23:12] ^ w[15:4]) & ~low) == 12'h000;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  oxad_pkg::oxad_state_t state_r, state_nxt;
  oxad_pkg::oxad_target_t tgt_r, tgt_nxt;
  logic busy_r, busy_nxt;
  logic sel_r, sel_nxt;
  logic err_r, err_nxt;
  logic done_r, done_nxt;
  logic [13:0] idx_r, idx_nxt;
  logic [2:0] set_r, set_nxt;
  logic [15:0] win_r, win_nxt;
  logic [7:0] vis_r, vis_nxt;
  logic [3:0] seg_r, seg_nxt;
  logic [1:0] waits;
  logic accept;
  logic wait_last;
  oxad_pkg::oxad_target_t dec_tgt;
  logic [13:0] dec_idx;
  logic [2:0] dec_set;
  logic dec_err;

  assign accept = (state_r == oxad_pkg::ST_IDLE) && i_req;

  // ---------------------------------------------------------------
  // address decode, first match wins
  // ---------------------------------------------------------------
  // the whole 24-bit space is one map; byte and word both pass except on peripherals
  // one flat byte-or-word map
  always_comb begin
    dec_tgt = oxad_pkg::TGT_EXT;
    dec_idx = 14'h0000;
    dec_set = 3'h0;
    dec_err = 1'b0;
    waits = EXT_W;
    if (i_bootstrap && i_addr <= `OXAD_TEST_HI) begin
      dec_tgt = oxad_pkg::TGT_FLASH_TEST;
      waits = `OXAD_RAM_WAITS;
    end else if (i_addr <= `OXAD_FL_A_HI || (i_addr >= `OXAD_FL_B_LO && i_addr <= `OXAD_FL_B_HI)) begin
      dec_tgt = oxad_pkg::TGT_FLASH;
      waits = `OXAD_RAM_WAITS;
    end else if (i_xbus_global_enable && i_xbus_periph_config[`OXAD_EN_SMALL_EXTENSION_RAM]
                 && i_addr >= `OXAD_SMALL_EXTENSION_RAM_LO && i_addr <= `OXAD_SMALL_EXTENSION_RAM_HI) begin
      dec_tgt = oxad_pkg::TGT_SMALL_EXTENSION_RAM;
      dec_idx = {3'h0, i_addr[10:0]};
      waits = `OXAD_RAM_WAITS;
    end else if (i_xbus_global_enable && i_xbus_periph_config[`OXAD_EN_LARGE_EXTENSION_RAM] && win_hit(i_addr, win_r)) begin
      dec_tgt = oxad_pkg::TGT_LARGE_EXTENSION_RAM;
      // low bits masked to the ram size, so the ram mirrors every 8 or 16 kbyte
      dec_idx = i_addr[13:0] & RAM_MASK;
      waits = `OXAD_RAM_WAITS;
    end else if (i_xbus_global_enable) begin
      for (int k = 0; k < 8; k++) begin
        if (i_xbus_periph_config[ENBIT[k]] && i_addr[23:8] == PAGE[k]) begin
          dec_tgt = PTGT[k];
          dec_idx = {6'h00, i_addr[7:0]};
          dec_err = i_byte;
          waits = `OXAD_XBUS_WAITS;
        end
      end
    end
    if (dec_tgt == oxad_pkg::TGT_EXT) begin
      for (int k = N_SEL - 1; k >= 0; k--) begin
        if (win_hit(i_addr, i_ext_address_select[k])) begin
          dec_set = 3'(k + 1);
        end
      end
    end
    // a refused byte access ends at once so the cpu is not stalled
    if (dec_err) begin
      waits = 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // access sequencing
  // ---------------------------------------------------------------
  // zero-wait targets finish with the select pulse, others hold busy
  always_comb begin
    state_nxt = state_r;
    tgt_nxt = tgt_r;
    idx_nxt = idx_r;
    set_nxt = set_r;
    sel_nxt = 1'b0;
    err_nxt = 1'b0;
    done_nxt = 1'b0;
    unique case (state_r)
      oxad_pkg::ST_IDLE: begin
        if (i_req) begin
          tgt_nxt = dec_tgt;
          idx_nxt = dec_idx;
          set_nxt = dec_set;
          sel_nxt = 1'b1;
          err_nxt = dec_err;
          if (waits == 2'h0) begin
            done_nxt = 1'b1;
          end else begin
            state_nxt = oxad_pkg::ST_WAIT;
          end
        end
      end
      oxad_pkg::ST_WAIT: begin
        if (wait_last) begin
          done_nxt = 1'b1;
          state_nxt = oxad_pkg::ST_IDLE;
        end
      end
    endcase
    busy_nxt = (state_nxt == oxad_pkg::ST_WAIT);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= oxad_pkg::ST_IDLE;
      tgt_r <= oxad_pkg::TGT_EXT;
      idx_r <= 14'h0000;
      set_r <= 3'h0;
      sel_r <= 1'b0;
      err_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tgt_r <= tgt_nxt;
      idx_r <= idx_nxt;
      set_r <= set_nxt;
      sel_r <= sel_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  oxad_wait_ctr u_wait (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(accept),
    .i_waits(waits),
    .o_last(wait_last)
  );

  // ---------------------------------------------------------------
  // window register and peripheral visibility
  // ---------------------------------------------------------------
  // visibility also tells the pin and interrupt owners which units may claim them
  always_comb begin
    win_nxt = i_xram_win_load ? i_xram_win_data : win_r;
    for (int k = 0; k < 8; k++) begin
      vis_nxt[k] = i_xbus_global_enable & i_xbus_periph_config[ENBIT[k]];
    end
    // can in use cuts segment lines
    seg_nxt = (vis_nxt[0] | vis_nxt[1]) ? `OXAD_SEG_LINES_CAN : `OXAD_SEG_LINES_FULL;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      win_r <= `OXAD_LARGE_EXTENSION_RAM_WIN_RST;
      vis_r <= 8'h00;
      seg_r <= `OXAD_SEG_LINES_FULL;
    end else begin
      win_r <= win_nxt;
      vis_r <= vis_nxt;
      seg_r <= seg_nxt;
    end
  end

  assign o_busy = busy_r;
  assign o_sel_valid = sel_r;
  assign o_target = tgt_r;
  assign o_ram_index = idx_r;
  assign o_ext_set = set_r;
  assign o_access_error = err_r;
  assign o_done = done_r;
  assign o_large_xram_window_select = win_r;
  assign o_periph_visible = vis_r;
  assign o_seg_addr_lines = seg_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_periph_taken;
    accept && !dec_err && dec_tgt inside {oxad_pkg::TGT_FIRST_CAN_CONTROLLER, oxad_pkg::TGT_SECOND_CAN_CONTROLLER, oxad_pkg::TGT_RTC,
        oxad_pkg::TGT_PWM, oxad_pkg::TGT_ASC, oxad_pkg::TGT_SSC, oxad_pkg::TGT_I2C, oxad_pkg::TGT_MISC};
  endsequence
  sequence s_two_waits;
    ##1 (o_sel_valid && o_busy && !o_done) ##1 (o_busy && !o_done) ##1 (o_done && !o_busy);
  endsequence

  a_small_extension_ram_gate: assert property (o_sel_valid && o_target == oxad_pkg::TGT_SMALL_EXTENSION_RAM |->
      $past(i_xbus_global_enable) && $past(i_xbus_periph_config[2]) && $past(i_addr[23:11]) == 13'h001C)
    else $error("small ram selected without enables or out of range");
  a_small_extension_ram_off: assert property (accept && !i_xbus_global_enable && i_addr[23:11] == 13'h001C |=>
      o_target == oxad_pkg::TGT_EXT)
    else $error("small ram range not sent external when disabled");
  a_large_extension_ram_gate: assert property (o_sel_valid && o_target == oxad_pkg::TGT_LARGE_EXTENSION_RAM |->
      $past(i_xbus_global_enable) && $past(i_xbus_periph_config[3]))
    else $error("large ram selected without enables");
  a_ram_nowait: assert property (accept && dec_tgt inside {oxad_pkg::TGT_SMALL_EXTENSION_RAM, oxad_pkg::TGT_LARGE_EXTENSION_RAM} |=>
      o_done && o_sel_valid && !o_busy)
    else $error("ram access not finished in one cycle");
  a_win_reset: assert property ($fell(i_rst) |-> o_large_xram_window_select == 16'h0902)
    else $error("large ram window not at reset value");
  a_periph_wait: assert property (s_periph_taken |-> s_two_waits)
    else $error("peripheral access not two wait states");
  a_byte_refuse: assert property (o_sel_valid && o_target == oxad_pkg::TGT_FIRST_CAN_CONTROLLER && $past(i_byte) |->
      o_access_error && o_done)
    else $error("byte access to peripheral not refused");
  a_periph_gate: assert property (o_sel_valid && o_target == oxad_pkg::TGT_I2C |->
      $past(i_xbus_global_enable) && $past(i_xbus_periph_config[9]) && $past(i_addr[23:8]) == 16'h00EA)
    else $error("i2c window decoded while disabled");
  a_can_seg: assert property (##1 (o_periph_visible[1:0] != 2'h0) |-> o_seg_addr_lines == 4'h4)
    else $error("segment lines not limited with can in use");
  a_boot_test: assert property (accept && i_bootstrap && i_addr < 24'h002000 |=>
      o_target == oxad_pkg::TGT_FLASH_TEST)
    else $error("test sector not shown in bootstrap");
  a_large_extension_ram_mirror: assert property (o_sel_valid && o_target == oxad_pkg::TGT_LARGE_EXTENSION_RAM |->
      o_ram_index == {(LARGE_XRAM_KB == 16) && $past(i_addr[13]), $past(i_addr[12:0])})
    else $error("large ram index not wrapped at its size");
  a_byte_allowed: assert property (accept && i_byte && dec_tgt inside {oxad_pkg::TGT_EXT,
      oxad_pkg::TGT_FLASH_TEST, oxad_pkg::TGT_FLASH, oxad_pkg::TGT_SMALL_EXTENSION_RAM, oxad_pkg::TGT_LARGE_EXTENSION_RAM} |=>
      o_sel_valid && !o_access_error)
    else $error("byte access refused outside peripheral pages");

endmodule

// ### rtl/oxad_wait_ctr.sv
// wait-state down counter for one access of the decoder
// assumes a load only while idle and a count of at least one
module oxad_wait_ctr (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [1:0] i_waits,
  output logic o_last
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  // load on accept, then count down to zero and stop
  always_comb begin
    cnt_nxt = cnt_r;
    if (i_load) begin
      cnt_nxt = i_waits;
    end else if (cnt_r != 2'h0) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_last = (cnt_r == 2'h1);

endmodule

// ### sim/oxad_cpu_model.sv
// cpu-side master model: issues one decoder access at a time and times it
// assumes the bench calls access() only while the decoder is idle
module oxad_cpu_model (
  input wire logic i_clk,
  input wire logic i_busy,
  input wire logic i_sel_valid,
  input wire logic i_access_error,
  input wire logic i_done,
  output logic o_req,
  output logic [23:0] o_addr,
  output logic o_byte
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // request driver
  // ---------------------------------------------------------------
  // idle bus at time zero
  initial begin
    o_req = 1'b0;
    o_addr = 24'h000000;
    o_byte = 1'b0;
  end

  // word or byte held until taken
  task automatic access(input logic [23:0] a, input logic b, output logic sv, output logic bz,
                        output logic er, output int lat);
    @(posedge i_clk);
    #1;
    o_req = 1'b1;
    o_addr = a;
    o_byte = b;
    @(posedge i_clk);
    #1;
    o_req = 1'b0;
    // released lines show the inverse so a stale value cannot pass
    o_addr = ~a;
    o_byte = ~b;
    sv = i_sel_valid;
    bz = i_busy;
    er = i_access_error;
    lat = 1;
    // bounded wait for completion, a hang shows up as a wrong latency
    while (i_done !== 1'b1 && lat < 8) begin
      @(posedge i_clk);
      #1;
      lat++;
    end
  endtask
endmodule

// ### sim/oxad_decoder_test.sv
// self-checking bench: random accesses against an integer model of the map
// assumes the decoder completes in one cycle for ram, three for peripheral words, two external
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s); end end

module oxad_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // signals and stimulus tables
  // ---------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_bootstrap = 1'b0;
  logic i_xbus_global_enable = 1'b0;
  logic i_xram_win_load = 1'b0;
  logic i_req, i_byte, o_busy, o_sel_valid, o_access_error, o_done;
  logic [23:0] i_addr;
  logic [15:0] i_xbus_periph_config = 16'h0000;
  logic [15:0] i_xram_win_data = 16'h0000;
  logic [15:0] i_ext_address_select [4] = '{16'h1003, 16'h2004, 16'h0E00, 16'h1004};
  oxad_pkg::oxad_target_t o_target;
  logic [13:0] o_ram_index;
  logic [2:0] o_ext_set;
  logic [15:0] o_large_xram_window_select;
  logic [7:0] o_periph_visible;
  logic [3:0] o_seg_addr_lines;
  int miscompares = 0;
  int n_tests = 0;
  logic [15:0] win = 16'h0902;
  logic [15:0] pg_t [8] = '{16'h00EF, 16'h00EE, 16'h00ED, 16'h00EC, 16'h00E9, 16'h00E8, 16'h00EA, 16'h00EB};
  int bit_t [8] = '{0, 1, 4, 6, 7, 8, 9, 10};
  logic [23:0] bases [8] = '{24'h000000, 24'h00E000, 24'h090000, 24'h100000, 24'h000000, 24'h00E800,
                             24'h04F000, 24'h200000};
  logic [23:0] masks [8] = '{24'h003FFF, 24'h000FFF, 24'h007FFF, 24'h00FFFF, 24'hFFFFFF, 24'h0007FF,
                             24'h001FFF, 24'h01FFFF};
  logic [15:0] wins [4] = '{16'h0902, 16'h0903, 16'h0A01, 16'h0900};

  // free-running 10 mhz clock
  always #50 i_clk = ~i_clk;

  oxad_decoder #(.LARGE_XRAM_KB(16), .EXT_WAITS(1), .N_SEL(4)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_addr(i_addr), .i_byte(i_byte),
    .i_bootstrap(i_bootstrap), .i_xbus_global_enable(i_xbus_global_enable),
    .i_xbus_periph_config(i_xbus_periph_config), .i_xram_win_load(i_xram_win_load),
    .i_xram_win_data(i_xram_win_data), .i_ext_address_select(i_ext_address_select),
    .o_busy(o_busy), .o_sel_valid(o_sel_valid), .o_target(o_target), .o_ram_index(o_ram_index),
    .o_ext_set(o_ext_set), .o_access_error(o_access_error), .o_done(o_done),
    .o_large_xram_window_select(o_large_xram_window_select), .o_periph_visible(o_periph_visible),
    .o_seg_addr_lines(o_seg_addr_lines));

  // 8 kbyte variant on the same inputs; only its ram index is compared
  logic [13:0] ram_index_8k;
  oxad_decoder #(.LARGE_XRAM_KB(8), .EXT_WAITS(1), .N_SEL(4)) dut8_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_addr(i_addr), .i_byte(i_byte),
    .i_bootstrap(i_bootstrap), .i_xbus_global_enable(i_xbus_global_enable),
    .i_xbus_periph_config(i_xbus_periph_config), .i_xram_win_load(i_xram_win_load),
    .i_xram_win_data(i_xram_win_data), .i_ext_address_select(i_ext_address_select),
    .o_busy(), .o_sel_valid(), .o_target(), .o_ram_index(ram_index_8k), .o_ext_set(),
    .o_access_error(), .o_done(), .o_large_xram_window_select(), .o_periph_visible(),
    .o_seg_addr_lines());

  oxad_cpu_model cpu_u (
    .i_clk(i_clk), .i_busy(o_busy), .i_sel_valid(o_sel_valid), .i_access_error(o_access_error),
    .i_done(o_done), .o_req(i_req), .o_addr(i_addr), .o_byte(i_byte));

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  // window or select word hit: start bits masked by the 4 kbyte << code span
  function automatic bit hit(input logic [15:0] w, input logic [23:0] a);
    logic [11:0] m;
    m = ~((12'h001 << w[3:0]) - 12'h001);
    return (a[23:12] & m) == (w[15:4] & m);
  endfunction

  // returns cycles to completion; target numbered as in the shared enum
  function automatic int expect_acc(input logic [23:0] a, input logic b, output int t, output int ix,
                                    output int st, output logic e);
    logic ge;
    int lat;
    ge = i_xbus_global_enable;
    t = 0;
    ix = 0;
    st = 0;
    e = 1'b0;
    lat = 1;
    if (i_bootstrap && a <= 24'h001FFF) t = 1;
    else if (a <= 24'h007FFF || (a >= 24'h018000 && a <= 24'h04FFFF)) t = 2;
    else if (ge && i_xbus_periph_config[2] && a >= 24'h00E000 && a <= 24'h00E7FF) begin
      t = 3;
      ix = a[10:0];
    end else if (ge && i_xbus_periph_config[3] && hit(win, a)) begin
      t = 4;
      ix = a[13:0];
    end else begin
      for (int k = 0; k < 8; k++) if (ge && i_xbus_periph_config[bit_t[k]] && a[23:8] == pg_t[k]) begin
        t = 5 + k;
        ix = a[7:0];
        e = b;
        lat = b ? 1 : 3;
      end
      // lowest matching select wins, so scan downwards
      if (t == 0) begin
        lat = 2;
        for (int k = 3; k >= 0; k--) if (hit(i_ext_address_select[k], a)) st = k + 1;
      end
    end
    return lat;
  endfunction

  // ---------------------------------------------------------------
  // closing and watchdog
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // under 1700 cycles are needed, so 1 ms only trips on a hang
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [23:0] a;
    logic b, e, sv, bz, er;
    logic [7:0] vis;
    int lat, el, t, ix, st;
    void'($urandom(32'hF0FDBC93));
    repeat (12) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    `CHK("window", 16'h0902, o_large_xram_window_select)
    `CHK("seg lines", 4'h8, o_seg_addr_lines)
    for (int n = 0; n < 400; n++) begin
      // new configuration and window every 16 accesses, while idle
      if (n % 16 == 0) begin
        i_xbus_global_enable = ($urandom % 4) != 0;
        i_xbus_periph_config = 16'($urandom);
        i_bootstrap = 1'($urandom);
        i_xram_win_load = 1'b1;
        i_xram_win_data = wins[$urandom % 4];
        win = i_xram_win_data;
        @(posedge i_clk);
        #1;
        i_xram_win_load = 1'b0;
        @(posedge i_clk);
        #1;
        vis = {i_xbus_periph_config[10:6], i_xbus_periph_config[4], i_xbus_periph_config[1:0]};
        vis = vis & {8{i_xbus_global_enable}};
        `CHK("window", win, o_large_xram_window_select)
        `CHK("visible", vis, o_periph_visible)
        `CHK("seg lines", (vis[1:0] != 2'h0) ? 4'h4 : 4'h8, o_seg_addr_lines)
      end
      a = bases[n % 8] | (24'($urandom) & masks[n % 8]);
      b = 1'($urandom);
      el = expect_acc(a, b, t, ix, st, e);
      cpu_u.access(a, b, sv, bz, er, lat);
      `CHK("sel valid", 1'b1, sv)
      `CHK("busy", el > 1, bz)
      `CHK("latency", el, lat)
      `CHK("target", 4'(t), o_target)
      `CHK("error", e, er)
      if (t >= 3) `CHK("index", 14'(ix), o_ram_index)
      if (t == 4) `CHK("index 8k", 14'(ix) & 14'h1FFF, ram_index_8k)
      if (t == 0) `CHK("ext set", 3'(st), o_ext_set)
    end
    stop_test();
  end
endmodule
